// *** src/mrc_pkg.sv ***
/*
 * package for the monitor result conditioning block: register offsets,
 * field positions, reset values, thresholds, states and carrier structs.
 * assumes a byte-wide register port driven by the two-wire slave logic.
 */
package mrc_pkg;

	// ============================================================
	// register offsets
	localparam logic [7:0] OFS_RX_MEAS_HI = 8'h68;
	localparam logic [7:0] OFS_RX_MEAS_LO = 8'h69;
	localparam logic [7:0] OFS_STATUS = 8'h6e;
	localparam logic [7:0] OFS_RANGE_FLAGS = 8'h6f;
	localparam logic [7:0] OFS_BUS_ADDR = 8'h8c;
	localparam logic [7:0] OFS_SHIFT_PRI = 8'h8e;
	localparam logic [7:0] OFS_SHIFT_SEC = 8'h8f;
	localparam logic [7:0] OFS_XC_HI = 8'h90;
	localparam logic [7:0] OFS_XC_LO = 8'h91;
	localparam logic [7:0] OFS_FG_HI = 8'h98;
	localparam logic [7:0] OFS_FG_LO = 8'h99;
	localparam logic [7:0] OFS_CG_HI = 8'h9c;
	localparam logic [7:0] OFS_CG_LO = 8'h9d;
	localparam logic [7:0] OFS_XF_HI = 8'ha0;
	localparam logic [7:0] OFS_XF_LO = 8'ha1;
	localparam logic [7:0] OFS_FO_HI = 8'ha8;
	localparam logic [7:0] OFS_FO_LO = 8'ha9;
	localparam logic [7:0] OFS_CO_HI = 8'hac;
	localparam logic [7:0] OFS_CO_LO = 8'had;

	// ============================================================
	// field positions
	localparam int SHP_BIAS_LSB = 0;
	localparam int SHP_POWER_LSB = 4;
	localparam int SHS_COARSE_LSB = 0;
	localparam int SHS_FINE_LSB = 4;
	localparam int ST_NOT_READY_BIT = 0;
	localparam int ST_VLOW_BIT = 1;
	localparam int RF_UPDATE_BIT = 0;
	localparam int RF_COARSE_BIT = 1;
	localparam int RF_APD_BIT = 7;

	// ============================================================
	// reset values and limits
	localparam logic [7:0] DEFAULT_BUS_ADDR = 8'ha2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] FINE_MAX_BASE = 16'hfff8;
	localparam logic [15:0] COARSE_MIN_BASE = 16'hf000;
	localparam logic [1:0] DRV_SHIFT_TWO = 2'h0;
	localparam logic [1:0] DRV_SHIFT_ONE = 2'h1;
	localparam int READY_TIME_US = 500;
	localparam int CLK_MHZ = 100;
	localparam int READY_CYCLES = READY_TIME_US * CLK_MHZ;

	// ============================================================
	// types
	typedef enum logic [3:0] {
		PWR_OFF = 4'b0001,
		PWR_RECALL = 4'b0010,
		PWR_RUN = 4'b0100,
		PWR_HOLD = 4'b1000
	} mrc_pwr_e;

	typedef enum logic [2:0] {
		CH_BIAS = 3'h0,
		CH_POWER = 3'h1,
		CH_COARSE = 3'h2,
		CH_FINE = 3'h3,
		CH_SUPPLY = 3'h4
	} mrc_chan_e;

	typedef struct packed {
		logic valid;
		mrc_chan_e chan;
		logic [15:0] data;
	} mrc_conv_s;

	typedef struct packed {
		logic valid;
		logic [3:0] index;
		logic [7:0] data;
	} mrc_nv_s;

endpackage : mrc_pkg

// *** src/mrc_core.sv ***
/*
 * monitor result conditioning: right-shift, monitor select, dual-range
 * receive power merge, power-on sequencing, ready flag, bus address.
 * assumes raw calibrated conversions, power-on levels already synchronised
 * as pins, and an nv recall stream of indexed bytes from the eeprom logic.
 */
`timescale 1ns/1ps

// Behaviour
// RQ1 - driver code 00 gives two shifts, 01 one, 10 and 11 none
// RQ2 - bias, power, coarse, fine each own a 3-bit nv shift count
// RQ3 - shift applied before alarm compare and before result registers
// RQ4 - shift applied during calibration setup too
// RQ5 - burst mode takes transmit power shift from the two driver codes
// RQ6 - before each shared monitor conversion, command matching driver signal
// RQ7 - bias and power paths have separate gain and offset
// RQ8 - coarse and fine receive conversions merge to a 16-bit result
// RQ9 - avalanche mode switches ranges without hysteresis, own calibration each
// RQ10 - fine crossover caps fine result before shifting
// RQ11 - coarse crossover floors coarse result before shifting
// RQ12 - pin mode switches ranges with hysteresis for best resolution
// RQ13 - pin thresholds halve per shift from FFF8h/F000h down
// RQ14 - below analog level: outputs off, defaults, shadow zero, analog off
// RQ15 - reaching analog level recalls shadowed settings, then enables analog
// RQ16 - dip between levels keeps settings, analog off, resumes at once
// RQ17 - below digital level returns defaults, fresh recall on next rise
// RQ18 - not ready flag set below analog level, clears within 500 us
// RQ19 - bus address is A2h until recall, then the configured one
// RQ20 - power-on raises unmaskable supply low alarm, cleared by good conversion
// RQ21 - transmit fault cannot latch until a good supply conversion
// RQ22 - burst mode ignores sampled power and uses computed value
// RQ23 - avalanche mode reports fine unless above crossover, else clamped coarse
module mrc_core #(
	parameter int READY_CNT = mrc_pkg::READY_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	input wire logic digital_power_on_level_i,
	input wire logic analog_power_on_level_i,
	input wire mrc_pkg::mrc_nv_s nv_i,
	input wire logic nv_done_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic conv_next_power_i,
	input wire mrc_pkg::mrc_conv_s conv_i,
	input wire logic [15:0] supply_low_limit_i,
	input wire logic burst_mode_i,
	input wire logic [15:0] burst_power_i,
	input wire logic [1:0] driver_shift_code_a_i,
	input wire logic [1:0] driver_shift_code_b_i,
	output logic monitor_select_power_o,
	output mrc_pkg::mrc_conv_s result_o,
	output logic nv_recall_o,
	output logic analog_enable_o,
	output logic outputs_enable_o,
	output logic fault_latch_allow_o,
	output logic supply_low_alarm_o,
	output logic not_ready_flag_o,
	output logic [7:0] bus_address_o
);

	// ============================================================
	// state
	typedef struct packed {
		mrc_pkg::mrc_pwr_e pwr;
		logic [31:0] rdy_cnt;
		logic not_ready;
		logic vlow;
		logic fault_ok;
		logic mon_power;
		logic [7:0] addr_cfg;
		logic [7:0] shift_pri;
		logic [7:0] shift_sec;
		logic [15:0] xc;
		logic [15:0] xf;
		logic [15:0] fg;
		logic [15:0] cg;
		logic [15:0] fo;
		logic [15:0] co;
		logic [15:0] fine_hold;
		logic fine_ok;
		logic use_coarse;
		logic avalanche_crossover_mode;
		logic update;
		logic [15:0] rx_meas;
		mrc_pkg::mrc_conv_s res;
	} mrc_state_s;

	mrc_state_s s_q;
	mrc_state_s s_d;

	logic [15:0] fine_max [8];
	logic [15:0] coarse_min [8];
	logic [15:0] mux_w;
	logic [2:0] sh_n;
	logic [2:0] drv_a;
	logic [2:0] drv_b;
	logic [15:0] shifted;
	logic [15:0] fine_v;
	logic [15:0] coarse_v;

	// ============================================================
	// pin mode thresholds, one entry per shift count
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_thr
			assign fine_max[gi] = mrc_pkg::FINE_MAX_BASE >> gi; // [RQ13]
			assign coarse_min[gi] = mrc_pkg::COARSE_MIN_BASE >> gi; // [RQ13]
		end
	endgenerate

	function automatic logic [2:0] drv_shift(input logic [1:0] code);
		unique case (code) // [RQ1]
			mrc_pkg::DRV_SHIFT_TWO: drv_shift = 3'h2;
			mrc_pkg::DRV_SHIFT_ONE: drv_shift = 3'h1;
			default: drv_shift = 3'h0;
		endcase
	endfunction : drv_shift

	function automatic logic [15:0] cal(input logic [15:0] raw,
			input logic [15:0] gain, input logic [15:0] ofs);
		logic [31:0] p;
		p = raw * gain;
		cal = p[30:15] + ofs;
	endfunction : cal

	assign drv_a = drv_shift(driver_shift_code_a_i);
	assign drv_b = drv_shift(driver_shift_code_b_i);

	// ============================================================
	// shift count selection, per channel from nv fields, burst power from the driver codes
	always_comb begin
		unique case (conv_i.chan) // [RQ2]
			mrc_pkg::CH_BIAS: sh_n = s_q.shift_pri[mrc_pkg::SHP_BIAS_LSB +: 3];
			mrc_pkg::CH_POWER: begin
				if (burst_mode_i) begin
					sh_n = 3'(drv_a + drv_b); // [RQ5]
				end else begin
					sh_n = s_q.shift_pri[mrc_pkg::SHP_POWER_LSB +: 3];
				end
			end
			mrc_pkg::CH_COARSE: sh_n = s_q.shift_sec[mrc_pkg::SHS_COARSE_LSB +: 3];
			mrc_pkg::CH_FINE: sh_n = s_q.shift_sec[mrc_pkg::SHS_FINE_LSB +: 3];
			default: sh_n = 3'h0;
		endcase
	end

	// fine crossover caps, coarse crossover floors, both before shifting
	assign fine_v = (conv_i.data > s_q.xf) ? s_q.xf : conv_i.data; // [RQ10]
	assign coarse_v = (conv_i.data < s_q.xc) ? s_q.xc : conv_i.data; // [RQ11]

	always_comb begin
		if (conv_i.chan == mrc_pkg::CH_POWER && burst_mode_i) begin
			mux_w = burst_power_i; // [RQ22]
		end else if (conv_i.chan == mrc_pkg::CH_FINE && s_q.avalanche_crossover_mode) begin
			mux_w = cal(fine_v, s_q.fg, s_q.fo); // [RQ9]
		end else if (conv_i.chan == mrc_pkg::CH_FINE) begin
			mux_w = cal(conv_i.data, s_q.fg, s_q.fo);
		end else if (conv_i.chan == mrc_pkg::CH_COARSE && s_q.avalanche_crossover_mode) begin
			mux_w = cal(coarse_v, s_q.cg, s_q.co); // [RQ9]
		end else if (conv_i.chan == mrc_pkg::CH_COARSE) begin
			mux_w = cal(conv_i.data, s_q.cg, s_q.co);
		end else begin
			// bias and power arrive with their own gain/offset already applied
			mux_w = conv_i.data; // [RQ7]
		end
	end

	// shift on every conversion, including calibration setup ones
	assign shifted = mux_w >> sh_n; // [RQ3] [RQ4]

	// ============================================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.res.valid = 1'b0;
		unique case (s_q.pwr)
			mrc_pkg::PWR_OFF: begin
				if (digital_power_on_level_i && analog_power_on_level_i) begin
					s_d.pwr = mrc_pkg::PWR_RECALL; // [RQ15]
				end
			end
			mrc_pkg::PWR_RECALL: begin
				if (!digital_power_on_level_i) begin
					s_d.pwr = mrc_pkg::PWR_OFF;
				end else if (nv_done_i) begin
					s_d.pwr = mrc_pkg::PWR_RUN; // [RQ15]
					s_d.rdy_cnt = 32'h0000_0000;
				end
			end
			mrc_pkg::PWR_RUN: begin
				if (!digital_power_on_level_i) begin
					s_d.pwr = mrc_pkg::PWR_OFF;
				end else if (!analog_power_on_level_i) begin
					s_d.pwr = mrc_pkg::PWR_HOLD; // [RQ16]
				end
			end
			mrc_pkg::PWR_HOLD: begin
				if (!digital_power_on_level_i) begin
					s_d.pwr = mrc_pkg::PWR_OFF; // [RQ17]
				end else if (analog_power_on_level_i) begin
					s_d.pwr = mrc_pkg::PWR_RUN; // [RQ16]
					s_d.rdy_cnt = 32'h0000_0000;
				end
			end
			default: s_d.pwr = mrc_pkg::PWR_OFF;
		endcase

		// ready timer, bounded by the parameter
		if (s_q.pwr == mrc_pkg::PWR_RUN && s_q.not_ready) begin
			if (s_q.rdy_cnt >= 32'(READY_CNT - 1)) begin
				s_d.not_ready = 1'b0; // [RQ18]
			end else begin
				s_d.rdy_cnt = s_q.rdy_cnt + 32'h0000_0001;
			end
		end
		if (!analog_power_on_level_i || s_q.pwr != mrc_pkg::PWR_RUN) begin
			s_d.not_ready = 1'b1; // [RQ18]
		end

		// alarm raised while analog is off, cleared only by a good conversion
		if (s_q.pwr != mrc_pkg::PWR_RUN || !analog_power_on_level_i) begin
			s_d.vlow = 1'b1; // [RQ20]
			s_d.fault_ok = 1'b0; // [RQ21]
		end else if (conv_i.valid && conv_i.chan == mrc_pkg::CH_SUPPLY
				&& conv_i.data > supply_low_limit_i) begin
			s_d.vlow = 1'b0; // [RQ20]
			s_d.fault_ok = 1'b1; // [RQ21]
		end

		// nv shadow recall; shadow copies hold zero until then
		if (s_q.pwr == mrc_pkg::PWR_RECALL && nv_i.valid) begin
			unique case (nv_i.index)
				4'h0: s_d.addr_cfg = nv_i.data; // [RQ19]
				4'h1: s_d.shift_pri = nv_i.data;
				4'h2: s_d.shift_sec = nv_i.data;
				4'h3: s_d.xc[15:8] = nv_i.data;
				4'h4: s_d.xc[7:0] = nv_i.data;
				4'h5: s_d.xf[15:8] = nv_i.data;
				4'h6: s_d.xf[7:0] = nv_i.data;
				4'h7: s_d.fg[15:8] = nv_i.data;
				4'h8: s_d.fg[7:0] = nv_i.data;
				4'h9: s_d.cg[15:8] = nv_i.data;
				4'ha: s_d.cg[7:0] = nv_i.data;
				4'hb: s_d.fo[15:8] = nv_i.data;
				4'hc: s_d.fo[7:0] = nv_i.data;
				4'hd: s_d.co[15:8] = nv_i.data;
				4'he: s_d.co[7:0] = nv_i.data;
				default: s_d.avalanche_crossover_mode = nv_i.data[mrc_pkg::RF_APD_BIT];
			endcase
		end

		// register writes from the host side
		if (reg_wr_i && s_q.pwr == mrc_pkg::PWR_RUN) begin
			unique case (reg_addr_i)
				mrc_pkg::OFS_BUS_ADDR: s_d.addr_cfg = reg_wdata_i;
				mrc_pkg::OFS_SHIFT_PRI: s_d.shift_pri = reg_wdata_i;
				mrc_pkg::OFS_SHIFT_SEC: s_d.shift_sec = reg_wdata_i;
				mrc_pkg::OFS_XC_HI: s_d.xc[15:8] = reg_wdata_i;
				mrc_pkg::OFS_XC_LO: s_d.xc[7:0] = reg_wdata_i;
				mrc_pkg::OFS_XF_HI: s_d.xf[15:8] = reg_wdata_i;
				mrc_pkg::OFS_XF_LO: s_d.xf[7:0] = reg_wdata_i;
				mrc_pkg::OFS_FG_HI: s_d.fg[15:8] = reg_wdata_i;
				mrc_pkg::OFS_FG_LO: s_d.fg[7:0] = reg_wdata_i;
				mrc_pkg::OFS_CG_HI: s_d.cg[15:8] = reg_wdata_i;
				mrc_pkg::OFS_CG_LO: s_d.cg[7:0] = reg_wdata_i;
				mrc_pkg::OFS_FO_HI: s_d.fo[15:8] = reg_wdata_i;
				mrc_pkg::OFS_FO_LO: s_d.fo[7:0] = reg_wdata_i;
				mrc_pkg::OFS_CO_HI: s_d.co[15:8] = reg_wdata_i;
				mrc_pkg::OFS_CO_LO: s_d.co[7:0] = reg_wdata_i;
				mrc_pkg::OFS_RANGE_FLAGS: begin
					s_d.avalanche_crossover_mode = reg_wdata_i[mrc_pkg::RF_APD_BIT];
					if (reg_wdata_i[mrc_pkg::RF_UPDATE_BIT]) begin
						s_d.update = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// toggle the driver monitor select ahead of the next shared conversion
		if (conv_next_power_i != s_q.mon_power) begin
			s_d.mon_power = conv_next_power_i; // [RQ6]
		end

		// conditioned results and receive power merge
		if (conv_i.valid && s_q.pwr == mrc_pkg::PWR_RUN) begin
			s_d.res.valid = 1'b1;
			s_d.res.chan = conv_i.chan;
			s_d.res.data = shifted; // [RQ3]
			if (conv_i.chan == mrc_pkg::CH_FINE) begin
				s_d.fine_hold = shifted;
				// avalanche: within crossover; pin: below its own full scale
				s_d.fine_ok = s_q.avalanche_crossover_mode ? (conv_i.data <= s_q.xf)
					: (mux_w < fine_max[sh_n]); // [RQ12] [RQ13] [RQ23]
			end
			if (conv_i.chan == mrc_pkg::CH_COARSE) begin // [RQ8]
				if (s_q.avalanche_crossover_mode) begin
					s_d.use_coarse = !s_q.fine_ok; // [RQ9] [RQ23]
				end else if (s_q.use_coarse) begin
					// stay coarse until raw falls below the coarse minimum
					s_d.use_coarse = !(conv_i.data < coarse_min[sh_n]); // [RQ12]
				end else begin
					// unshifted fine judged at its own shift, no bits lost
					s_d.use_coarse = !s_q.fine_ok; // [RQ12]
				end
				s_d.rx_meas = s_d.use_coarse ? shifted : s_q.fine_hold; // [RQ8]
				s_d.update = 1'b1; // set wins over a same-cycle clear
			end
		end

		// off state (below digital level, or analog level not yet reached): volatile defaults held, shadow zeroed
		if (s_q.pwr == mrc_pkg::PWR_OFF) begin
			s_d.addr_cfg = mrc_pkg::RST_BYTE; // [RQ14] [RQ17]
			s_d.shift_pri = mrc_pkg::RST_BYTE;
			s_d.shift_sec = mrc_pkg::RST_BYTE;
			s_d.xc = mrc_pkg::RST_WORD;
			s_d.xf = mrc_pkg::RST_WORD;
			s_d.fg = mrc_pkg::RST_WORD;
			s_d.cg = mrc_pkg::RST_WORD;
			s_d.fo = mrc_pkg::RST_WORD;
			s_d.co = mrc_pkg::RST_WORD;
			s_d.rx_meas = mrc_pkg::RST_WORD;
			s_d.avalanche_crossover_mode = 1'b0;
			s_d.update = 1'b0;
			s_d.use_coarse = 1'b0;
		end
	end

	// ============================================================
	// state register; clock enable freezes everything
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_q <= '0;
			s_q.pwr <= mrc_pkg::PWR_OFF;
			s_q.not_ready <= 1'b1;
			s_q.vlow <= 1'b1;
		end else if (clk_en_i) begin
			s_q <= s_d;
		end
	end

	// ============================================================
	// register read port
	always_comb begin
		unique case (reg_addr_i)
			mrc_pkg::OFS_RX_MEAS_HI: reg_rdata_o = s_q.rx_meas[15:8];
			mrc_pkg::OFS_RX_MEAS_LO: reg_rdata_o = s_q.rx_meas[7:0];
			mrc_pkg::OFS_STATUS: reg_rdata_o = {6'h00, s_q.vlow, s_q.not_ready};
			mrc_pkg::OFS_RANGE_FLAGS:
				reg_rdata_o = {s_q.avalanche_crossover_mode, 5'h00, s_q.use_coarse, s_q.update};
			mrc_pkg::OFS_BUS_ADDR: reg_rdata_o = s_q.addr_cfg;
			mrc_pkg::OFS_SHIFT_PRI: reg_rdata_o = s_q.shift_pri;
			mrc_pkg::OFS_SHIFT_SEC: reg_rdata_o = s_q.shift_sec;
			mrc_pkg::OFS_XC_HI: reg_rdata_o = s_q.xc[15:8];
			mrc_pkg::OFS_XC_LO: reg_rdata_o = s_q.xc[7:0];
			mrc_pkg::OFS_XF_HI: reg_rdata_o = s_q.xf[15:8];
			mrc_pkg::OFS_XF_LO: reg_rdata_o = s_q.xf[7:0];
			mrc_pkg::OFS_FG_HI: reg_rdata_o = s_q.fg[15:8];
			mrc_pkg::OFS_FG_LO: reg_rdata_o = s_q.fg[7:0];
			mrc_pkg::OFS_CG_HI: reg_rdata_o = s_q.cg[15:8];
			mrc_pkg::OFS_CG_LO: reg_rdata_o = s_q.cg[7:0];
			mrc_pkg::OFS_FO_HI: reg_rdata_o = s_q.fo[15:8];
			mrc_pkg::OFS_FO_LO: reg_rdata_o = s_q.fo[7:0];
			mrc_pkg::OFS_CO_HI: reg_rdata_o = s_q.co[15:8];
			mrc_pkg::OFS_CO_LO: reg_rdata_o = s_q.co[7:0];
			default: reg_rdata_o = 8'h00;
		endcase
	end

	// ============================================================
	// outputs
	assign monitor_select_power_o = s_q.mon_power;
	assign result_o = s_q.res;
	assign nv_recall_o = (s_q.pwr == mrc_pkg::PWR_RECALL); // [RQ15]
	// analog only after recall done, and above the analog level except for one cycle when a recall ends below it
	assign analog_enable_o = (s_q.pwr == mrc_pkg::PWR_RUN); // [RQ14] [RQ16]
	assign outputs_enable_o = (s_q.pwr == mrc_pkg::PWR_RUN); // [RQ14]
	assign fault_latch_allow_o = s_q.fault_ok; // [RQ21]
	assign supply_low_alarm_o = s_q.vlow; // [RQ20]
	assign not_ready_flag_o = s_q.not_ready; // [RQ18]
	assign bus_address_o = (s_q.pwr == mrc_pkg::PWR_RUN
		|| s_q.pwr == mrc_pkg::PWR_HOLD)
		? s_q.addr_cfg : mrc_pkg::DEFAULT_BUS_ADDR; // [RQ19]

endmodule : mrc_core

// *** verification/mrc_nv_model.sv ***
/*
 * recall source model: streams the sixteen indexed nv bytes while the
 * block asks for a recall, then pulses done once.
 * assumes one clock shared with the block and an image given as a vector.
 */
`timescale 1ns/1ps
module mrc_nv_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic recall_i,
	input wire logic slow_i,
	input wire logic [127:0] image_i,
	output mrc_pkg::mrc_nv_s nv_o,
	output logic done_o
);
	// ============================================================
	// stream
	logic [4:0] idx_q;
	logic gap_q;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			idx_q <= 5'h00;
			gap_q <= 1'b0;
			nv_o <= '0;
			done_o <= 1'b0;
		end else begin
			nv_o.valid <= 1'b0;
			// idle data keeps changing so a stale byte cannot pass as fresh
			nv_o.data <= ~nv_o.data;
			done_o <= 1'b0;
			gap_q <= slow_i && !gap_q;
			if (!recall_i) begin
				idx_q <= 5'h00;
			end else if (idx_q == 5'h10) begin
				done_o <= 1'b1;
				idx_q <= 5'h11;
			end else if (idx_q < 5'h10 && !gap_q) begin
				nv_o <= {1'b1, idx_q[3:0], image_i[8*idx_q[3:0] +: 8]};
				idx_q <= idx_q + 5'h01;
			end
		end
	end
endmodule : mrc_nv_model

// *** verification/mrc_core_checker.sv ***
/*
 * port checker for mrc_core: result timing, monitor select, power states,
 * alarm, fault gate and bus address.
 * assumes it is bound into every mrc_core instance.
 */
`timescale 1ns/1ps
module mrc_core_checker (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic clk_en_i,
	input wire logic analog_power_on_level_i,
	input wire logic conv_next_power_i,
	input wire mrc_pkg::mrc_conv_s conv_i,
	input wire logic [15:0] supply_low_limit_i,
	input wire logic monitor_select_power_o,
	input wire mrc_pkg::mrc_conv_s result_o,
	input wire logic nv_recall_o,
	input wire logic analog_enable_o,
	input wire logic outputs_enable_o,
	input wire logic fault_latch_allow_o,
	input wire logic supply_low_alarm_o,
	input wire logic not_ready_flag_o,
	input wire logic [7:0] bus_address_o
);
	// ============================================================
	// assertions
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rstn_i);
	wire logic good_sup = conv_i.valid && conv_i.chan == mrc_pkg::CH_SUPPLY
		&& conv_i.data > supply_low_limit_i;
	wire logic taken = conv_i.valid && analog_enable_o && clk_en_i;
	a_result_latency: assert property (
		taken |=> result_o.valid && result_o.chan == $past(conv_i.chan))
		else $error("no result after a taken conversion");
	a_no_stray_result: assert property (
		clk_en_i && !taken |=> !result_o.valid)
		else $error("result without a taken conversion");
	a_monitor_follow: assert property (
		clk_en_i |=> monitor_select_power_o == $past(conv_next_power_i))
		else $error("monitor select did not follow request");
	a_low_supply_flags: assert property (
		clk_en_i && !analog_power_on_level_i
		|=> not_ready_flag_o && supply_low_alarm_o)
		else $error("flags clear below analog level");
	a_low_supply_off: assert property (
		clk_en_i && !analog_power_on_level_i
		|=> !analog_enable_o && !outputs_enable_o)
		else $error("analog or outputs on below analog level");
	a_recall_quiet: assert property (
		nv_recall_o |-> !analog_enable_o && !outputs_enable_o)
		else $error("analog on during recall");
	a_addr_default: assert property (
		nv_recall_o |-> bus_address_o == mrc_pkg::DEFAULT_BUS_ADDR)
		else $error("bus address not default before recall done");
	a_alarm_clear: assert property (
		$fell(supply_low_alarm_o) |-> $past(good_sup))
		else $error("alarm cleared without good supply conversion");
	a_fault_gate: assert property (
		$rose(fault_latch_allow_o) |-> $past(good_sup))
		else $error("fault latch allowed without good supply conversion");
	c_coarse: cover property (result_o.valid
		&& result_o.chan == mrc_pkg::CH_COARSE);
	c_alarm_clear: cover property ($fell(supply_low_alarm_o));
	c_recall: cover property ($rose(nv_recall_o));
endmodule : mrc_core_checker

bind mrc_core mrc_core_checker mrc_core_checker_i (
	.clk_sys_i(clk_sys_i),
	.rstn_i(rstn_i),
	.clk_en_i(clk_en_i),
	.analog_power_on_level_i(analog_power_on_level_i),
	.conv_next_power_i(conv_next_power_i),
	.conv_i(conv_i),
	.supply_low_limit_i(supply_low_limit_i),
	.monitor_select_power_o(monitor_select_power_o),
	.result_o(result_o),
	.nv_recall_o(nv_recall_o),
	.analog_enable_o(analog_enable_o),
	.outputs_enable_o(outputs_enable_o),
	.fault_latch_allow_o(fault_latch_allow_o),
	.supply_low_alarm_o(supply_low_alarm_o),
	.not_ready_flag_o(not_ready_flag_o),
	.bus_address_o(bus_address_o)
);

// *** verification/mrc_core_test.sv ***
/*
 * self-checking bench for mrc_core: register port, shifts, burst power,
 * dual-range merge, supply alarm and power sequencing.
 * assumes the recall model and the bound checker are compiled before it.
 */
`timescale 1ns/1ps
module mrc_core_test;
	// ============================================================
	// signals
	// recall image: addr b4, shifts 53/21, xc 2000, xf 1000, gains 8000, apd
	localparam logic [127:0] IMAGE =
		128'h8000_0000_0000_8000_8000_1000_2021_53b4;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic dig_on = 1'b0;
	logic ana_on = 1'b0;
	logic wr_en = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic next_pwr = 1'b0;
	mrc_pkg::mrc_conv_s conv = '0;
	logic burst = 1'b0;
	logic [15:0] bpow = 16'hf0f0;
	logic [1:0] code_a = 2'h0;
	logic [1:0] code_b = 2'h0;
	logic slow = 1'b0;
	logic seen = 1'b0;
	logic clk_en = 1'b1;
	mrc_pkg::mrc_nv_s nv;
	mrc_pkg::mrc_conv_s result;
	mrc_pkg::mrc_conv_s res;
	logic nv_done, mon, recall, aen, oen, fault_ok, alarm, not_rdy;
	logic [7:0] rdata;
	logic [7:0] bus_addr;
	int n_tests = 0;
	int n_mismatch = 0;

	always #5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (recall === 1'b1) seen = 1'b1;

	mrc_core #(.READY_CNT(10)) mrc_core_i (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.clk_en_i(clk_en),
		.digital_power_on_level_i(dig_on),
		.analog_power_on_level_i(ana_on),
		.nv_i(nv),
		.nv_done_i(nv_done),
		.reg_wr_i(wr_en),
		.reg_addr_i(addr),
		.reg_wdata_i(wdata),
		.reg_rdata_o(rdata),
		.conv_next_power_i(next_pwr),
		.conv_i(conv),
		.supply_low_limit_i(16'h8000),
		.burst_mode_i(burst),
		.burst_power_i(bpow),
		.driver_shift_code_a_i(code_a),
		.driver_shift_code_b_i(code_b),
		.monitor_select_power_o(mon),
		.result_o(result),
		.nv_recall_o(recall),
		.analog_enable_o(aen),
		.outputs_enable_o(oen),
		.fault_latch_allow_o(fault_ok),
		.supply_low_alarm_o(alarm),
		.not_ready_flag_o(not_rdy),
		.bus_address_o(bus_addr)
	);
	mrc_nv_model mrc_nv_model_i (
		.clk_i(clk_sys_i),
		.rstn_i(rstn_i),
		.recall_i(recall),
		.slow_i(slow),
		.image_i(IMAGE),
		.nv_o(nv),
		.done_o(nv_done)
	);

	// ============================================================
	// tasks
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report
	task automatic chk(input string what, input logic [15:0] e, got);
		n_tests++;
		if (got !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", what, e, got);
			n_mismatch++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		@(negedge clk_sys_i);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk_sys_i);
		wr_en = 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, e);
		@(negedge clk_sys_i);
		addr = a;
		#1;
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdata});
	endtask : rdc
	task automatic cv(input mrc_pkg::mrc_chan_e ch, input logic [15:0] d);
		@(negedge clk_sys_i);
		conv = {1'b1, ch, d};
		@(negedge clk_sys_i);
		res = result;
		conv.valid = 1'b0;
	endtask : cv
	task automatic rx(input logic [15:0] f, c, e);
		cv(mrc_pkg::CH_FINE, f);
		cv(mrc_pkg::CH_COARSE, c);
		rdc(8'h68, e[15:8]);
		rdc(8'h69, e[7:0]);
	endtask : rx
	// every wait is bounded; running out ends the run as a failure
	task automatic wait_for(input bit rdy, input logic v, output int n);
		for (n = 0; n < 100; n++) begin
			if ((rdy ? not_rdy : aen) === v) return;
			@(negedge clk_sys_i);
		end
		$display("CHECK FAILED wait expected %b seen timeout", v);
		n_mismatch++;
		final_report();
	endtask : wait_for
	task automatic power_up;
		int n;
		@(negedge clk_sys_i);
		seen = 1'b0;
		dig_on = 1'b1;
		ana_on = 1'b1;
		wait_for(1'b0, 1'b1, n);
		chk("recall seen", 16'h0001, {15'h0000, seen});
		chk("bus addr", 16'h00b4, {8'h00, bus_addr});
		wait_for(1'b1, 1'b0, n);
		chk("ready time", 16'h0001, {15'h0000, n <= 12});
	endtask : power_up
	function automatic int sh(input int c);
		return (c == 0) ? 2 : (c == 1) ? 1 : 0;
	endfunction : sh

	// ============================================================
	// sequence
	initial begin
		int n;
		repeat (10) @(negedge clk_sys_i);
		rstn_i = 1'b1;
		chk("not ready", 16'h0001, {15'h0000, not_rdy});
		chk("alarm", 16'h0001, {15'h0000, alarm});
		chk("enables", 16'h0000, {14'h0000, aen, oen});
		chk("bus addr", 16'h00a2, {8'h00, bus_addr});
		wr(8'h8e, 8'h77);
		rdc(8'h8e, 8'h00);
		power_up();
		rdc(8'h8e, 8'h53);
		rdc(8'h8f, 8'h21);
		rdc(8'h70, 8'h00);
		wr(8'h91, 8'h5a);
		rdc(8'h91, 8'h5a);
		wr(8'h91, 8'h00);
		next_pwr = 1'b1;
		@(negedge clk_sys_i);
		chk("monitor select", 16'h0001, {15'h0000, mon});
		next_pwr = 1'b0;
		@(negedge clk_sys_i);
		chk("monitor select", 16'h0000, {15'h0000, mon});
		cv(mrc_pkg::CH_BIAS, 16'habcd);
		chk("bias", 16'h1579, res.data);
		cv(mrc_pkg::CH_POWER, 16'h1234);
		chk("power", 16'h0091, res.data);
		burst = 1'b1;
		for (int a = 0; a < 4; a++) begin
			for (int b = 0; b < 4; b++) begin
				code_a = 2'(a);
				code_b = 2'(b);
				cv(mrc_pkg::CH_POWER, 16'h1234);
				chk("burst", bpow >> (sh(a) + sh(b)), res.data);
			end
		end
		burst = 1'b0;
		rx(16'h0800, 16'h0400, 16'h0200);
		rx(16'h1000, 16'h0400, 16'h0400);
		rx(16'h1800, 16'h0400, 16'h1000);
		rx(16'h1800, 16'h6000, 16'h3000);
		rdc(8'h6f, 8'h83);
		wr(8'h6f, 8'h81);
		rdc(8'h6f, 8'h82);
		wr(8'h68, 8'hff);
		rdc(8'h68, 8'h30);
		wr(8'h6f, 8'h01);
		rx(16'hfff8, 16'hf000, 16'h7800);
		rx(16'h2000, 16'hf000, 16'h7800);
		rx(16'h0100, 16'h0100, 16'h0040);
		rx(16'h3ffd, 16'h7800, 16'h0fff);
		rx(16'h3ffe, 16'h7800, 16'h3c00);
		// a good conversion while frozen must be lost
		@(negedge clk_sys_i);
		clk_en = 1'b0;
		cv(mrc_pkg::CH_SUPPLY, 16'h8001);
		clk_en = 1'b1;
		chk("frozen alarm", 16'h0001, {15'h0000, alarm});
		cv(mrc_pkg::CH_SUPPLY, 16'h8000);
		chk("alarm at limit", 16'h0001, {15'h0000, alarm});
		chk("fault gate", 16'h0000, {15'h0000, fault_ok});
		cv(mrc_pkg::CH_SUPPLY, 16'h8001);
		chk("alarm cleared", 16'h0000, {15'h0000, alarm});
		chk("fault gate", 16'h0001, {15'h0000, fault_ok});
		ana_on = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		chk("hold enables", 16'h0000, {14'h0000, aen, oen});
		chk("hold flags", 16'h0003, {14'h0000, not_rdy, alarm});
		rdc(8'h8e, 8'h53);
		seen = 1'b0;
		ana_on = 1'b1;
		wait_for(1'b0, 1'b1, n);
		chk("resume", 16'h0001, {15'h0000, n <= 2});
		chk("no recall", 16'h0000, {15'h0000, seen});
		dig_on = 1'b0;
		ana_on = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		chk("bus addr", 16'h00a2, {8'h00, bus_addr});
		rdc(8'h8e, 8'h00);
		slow = 1'b1;
		power_up();
		rdc(8'h8e, 8'h53);
		final_report();
	end
endmodule : mrc_core_test
